/* rtl/powergood_delay_pad_status.sv */
// Operation
// RULE_01: power-good pin asserts a programmed delay after internal valid.
// RULE_02: delay timed by shared clock if present, else the oscillator.
// RULE_03: delay clamped to 13.1 s and rounded to nearest 200us step.
// RULE_04: delay register reads back exactly the value last written.
// RULE_05: delay value is L11 encoded, units of milliseconds.
// RULE_06: select 1 deasserts via undervoltage limit and fast comparator.
// RULE_07: select 0 deasserts via power-good-off threshold, slow polling.
// RULE_08: pad status is read-only; input bits show raw undeglitched pads.
// RULE_09: bit 15 reads 0 while power-good pad is pulled low.
// RULE_10: bit 14 reads 0 while alert pad is pulled low.
// RULE_11: bits 13:10 read 0 while matching fault bus pad is pulled low.
// RULE_12: field bit 3 is fault pad 00 down to bit 0 pad 11.
// RULE_13: bits 9:8 show address pad 1: 11 high, 10 float, 00 low.
// RULE_14: bits 7:6 show address pad 0 with the same encoding.
// RULE_15: bit 5 is control pad 1 level, bit 4 control pad 0.
// RULE_16: bits 3:0 show raw level of each fault bus pad.
// RULE_17: valid drop during the delay restarts it; output stays off.
`timescale 1ns/1ps
module powergood_delay_pad_status #(
   parameter int STEP_CYC = pg_delay_pkg::STEP_CYCLES,
   parameter int LOSS_CYC = pg_delay_pkg::SHARE_LOSS_CYCLES,
   parameter int SHARE_EDGES = pg_delay_pkg::SHARE_EDGES_PER_STEP
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pg_delay_pkg::ADDR_W-1:0] paddr,
   input wire logic [pg_delay_pkg::DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [pg_delay_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic share_clk,
   input wire logic pg_internal_valid,
   input wire logic uv_fast_fault,
   input wire logic pg_off_below_threshold,
   input wire logic alert_pull_req,
   input wire logic [pg_delay_pkg::FAULT_PADS-1:0] fault_pull_req,
   input wire logic pwrgd_pad_i,
   output logic pwrgd_pad_o,
   output logic pwrgd_pad_oe,
   input wire logic alert_pad_i,
   output logic alert_pad_o,
   output logic alert_pad_oe,
   input wire logic [pg_delay_pkg::FAULT_PADS-1:0] fault_bus_pad_i,
   output logic [pg_delay_pkg::FAULT_PADS-1:0] fault_bus_pad_o,
   output logic [pg_delay_pkg::FAULT_PADS-1:0] fault_bus_pad_oe,
   input wire logic addr_select_pad0,
   input wire logic addr_select_pad0_float,
   input wire logic addr_select_pad1,
   input wire logic addr_select_pad1_float,
   input wire logic channel_control_pad0,
   input wire logic channel_control_pad1,
   output logic pg_out
);
   import pg_delay_pkg::*;

   // ==========================================================
   // declarations
   // ==========================================================
   logic [REG_W-1:0] power_good_assert_delay;
   logic pg_off_source_select;
   logic [STEP_W-1:0] delay_steps;
   logic [STEP_W-1:0] step_count;
   logic step_tick;
   logic share_present;
   pg_state_e pg_state;
   pg_state_e next_pg_state;
   logic off_condition;
   logic delay_done;
   logic setup_phase;
   logic access_phase;
   logic addr_hit;
   logic addr_ro;
   logic [REG_W-1:0] pad_level_status;
   logic [1:0] addr_select1_state;
   logic [1:0] addr_select0_state;
   logic [FAULT_PADS-1:0] fault_drive_state;
   logic [FAULT_PADS-1:0] fault_level_state;
   logic alert_drive_low;
   logic [FAULT_PADS-1:0] fault_drive_low;

   // ==========================================================
   // helpers
   // ==========================================================
   // three-state pad code; float wins over the sampled level
   function automatic logic [1:0] asel_code(
      input logic level,
      input logic floating
   );
      logic [1:0] code;
      code = ASEL_LOW;
      if (floating) begin
         code = ASEL_FLOAT;
      end else if (level) begin
         code = ASEL_HIGH;
      end
      return code;
   endfunction : asel_code

   // fault pad n sits at field bit (pads-1-n)
   function automatic logic [FAULT_PADS-1:0] fault_order(
      input logic [FAULT_PADS-1:0] by_pad
   );
      logic [FAULT_PADS-1:0] field;
      field = '0;
      for (int i = 0; i < FAULT_PADS; i++) begin
         field[FAULT_PADS-1-i] = by_pad[i];
      end
      return field;
   endfunction : fault_order

   // ==========================================================
   // time base and delay decode
   // ==========================================================
   pg_time_base #(
      .STEP_CYC(STEP_CYC),
      .LOSS_CYC(LOSS_CYC),
      .SHARE_EDGES(SHARE_EDGES)
   ) u_time_base (
      .pclk(pclk),
      .presetn(presetn),
      .share_clk(share_clk),
      .step_tick(step_tick),
      .share_present(share_present)
   );

   l11_delay_decode u_decode (
      .pclk(pclk),
      .presetn(presetn),
      .l11_value(power_good_assert_delay),
      .steps(delay_steps)
   );

   // ==========================================================
   // power-good sequencing
   // ==========================================================
   // RULE_06: fast undervoltage path
   // RULE_07: slow threshold path
   assign off_condition = pg_off_source_select ? uv_fast_fault :
                          pg_off_below_threshold;
   assign delay_done = (step_count >= delay_steps);

   // next state of the power-good sequencer
   always_comb begin
      next_pg_state = pg_state;
      case (pg_state)
         PG_OFF: begin
            if (pg_internal_valid) begin
               next_pg_state = PG_WAIT;
            end
         end
         PG_WAIT: begin
            // RULE_17: drop restarts wait
            if (!pg_internal_valid) begin
               next_pg_state = PG_OFF;
            // RULE_01: assert after delay
            end else if (delay_done) begin
               next_pg_state = PG_ON;
            end
         end
         PG_ON: begin
            // RULE_06: deassert on fault
            if (off_condition || !pg_internal_valid) begin
               next_pg_state = PG_OFF;
            end
         end
         default: begin
            next_pg_state = PG_OFF;
         end
      endcase
   end

   // sequencer state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pg_state <= PG_OFF;
      end else begin
         pg_state <= next_pg_state;
      end
   end

   // RULE_02: count time-base steps
   // RULE_17: counter restarts
   // counter saturates, so a long wait never wraps to a short one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_count <= '0;
      end else if (pg_state != PG_WAIT) begin
         step_count <= '0;
      end else if (step_tick && !delay_done) begin
         step_count <= step_count + STEP_W'(1);
      end
   end

   // RULE_01: drive power-good output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pg_out <= 1'b0;
      end else begin
         pg_out <= (next_pg_state == PG_ON);
      end
   end

   // ==========================================================
   // open-drain pad drivers
   // ==========================================================
   // pads only ever pull low; the level high comes from the pull-up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alert_drive_low <= 1'b0;
         fault_drive_low <= '0;
      end else begin
         alert_drive_low <= alert_pull_req;
         fault_drive_low <= fault_pull_req;
      end
   end

   assign pwrgd_pad_o = 1'b0;
   assign pwrgd_pad_oe = ~pg_out;
   assign alert_pad_o = 1'b0;
   assign alert_pad_oe = alert_drive_low;
   assign fault_bus_pad_o = '0;
   assign fault_bus_pad_oe = fault_drive_low;

   // ==========================================================
   // pad status word
   // ==========================================================
   // RULE_13: address pad 1 code
   // RULE_14: address pad 0 code
   assign addr_select1_state = asel_code(addr_select_pad1,
                                         addr_select_pad1_float);
   assign addr_select0_state = asel_code(addr_select_pad0,
                                         addr_select_pad0_float);
   // RULE_11: drive state low-active
   // RULE_12: pad to bit order
   assign fault_drive_state = fault_order(~fault_bus_pad_oe);
   // RULE_16: raw fault levels
   assign fault_level_state = fault_order(fault_bus_pad_i);

   // RULE_08: raw undeglitched pads
   always_comb begin
      pad_level_status = '0;
      // RULE_09: power-good drive bit
      pad_level_status[PAD_PG_DRIVE_BIT] = ~pwrgd_pad_oe;
      // RULE_10: alert drive bit
      pad_level_status[PAD_ALERT_DRIVE_BIT] = ~alert_pad_oe;
      pad_level_status[PAD_FAULT_DRIVE_LSB +: FAULT_PADS] =
         fault_drive_state;
      pad_level_status[PAD_ADDR_SELECT_PAD1_LSB +: 2] = addr_select1_state;
      pad_level_status[PAD_ADDR_SELECT_PAD0_LSB +: 2] = addr_select0_state;
      // RULE_15: control pad levels
      pad_level_status[PAD_CTRL1_BIT] = channel_control_pad1;
      pad_level_status[PAD_CTRL0_BIT] = channel_control_pad0;
      pad_level_status[PAD_FAULT_LVL_LSB +: FAULT_PADS] =
         fault_level_state;
   end

   // ==========================================================
   // APB slave
   // ==========================================================
   assign setup_phase = psel & ~penable;
   assign access_phase = psel & penable;
   assign pready = 1'b1;

   // address decode; read-only words refuse writes
   always_comb begin
      addr_hit = 1'b0;
      addr_ro = 1'b0;
      case (paddr)
         OFS_ASSERT_DELAY: begin
            addr_hit = 1'b1;
         end
         OFS_CONFIG: begin
            addr_hit = 1'b1;
         end
         OFS_PAD_STATUS: begin
            addr_hit = 1'b1;
            addr_ro = 1'b1;
         end
         OFS_STATE: begin
            addr_hit = 1'b1;
            addr_ro = 1'b1;
         end
         default: begin
            addr_hit = 1'b0;
         end
      endcase
   end

   // error on unmapped address or write to a read-only word
   assign pslverr = access_phase & (~addr_hit | (pwrite & addr_ro));

   // RULE_04: store raw written value
   // only the clamped copy in the decoder is used for timing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_good_assert_delay <= RST_ASSERT_DELAY;
      end else if (access_phase && pwrite &&
                   paddr == OFS_ASSERT_DELAY) begin
         if (pstrb[0]) begin
            power_good_assert_delay[7:0] <= pwdata[7:0];
         end
         if (pstrb[1]) begin
            power_good_assert_delay[15:8] <= pwdata[15:8];
         end
      end
   end

   // off-source select bit in the configuration word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pg_off_source_select <= RST_OFF_SOURCE;
      end else if (access_phase && pwrite && pstrb[0] &&
                   paddr == OFS_CONFIG) begin
         pg_off_source_select <= pwdata[CFG_OFF_SOURCE_BIT];
      end
   end

   // read data captured in the setup cycle, held through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= DATA_ZERO;
      end else if (setup_phase && !pwrite) begin
         prdata <= DATA_ZERO;
         case (paddr)
            OFS_ASSERT_DELAY: begin
               // RULE_04: exact readback
               prdata[REG_W-1:0] <= power_good_assert_delay;
            end
            OFS_PAD_STATUS: begin
               prdata[REG_W-1:0] <= pad_level_status;
            end
            OFS_CONFIG: begin
               prdata[CFG_OFF_SOURCE_BIT] <= pg_off_source_select;
            end
            OFS_STATE: begin
               prdata[ST_PG_OUT_BIT] <= pg_out;
               prdata[ST_SHARE_BIT] <= share_present;
               prdata[ST_WAIT_BIT] <= (pg_state == PG_WAIT);
            end
            default: begin
               prdata <= DATA_ZERO;
            end
         endcase
      end
   end

endmodule : powergood_delay_pad_status

/* rtl/pg_delay_pkg.sv */
package pg_delay_pkg;

   // ==========================================================
   // bus and register map
   // ==========================================================
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;
   localparam logic [ADDR_W-1:0] OFS_ASSERT_DELAY = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_PAD_STATUS = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_CONFIG = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_STATE = 12'h00C;
   localparam logic [REG_W-1:0] RST_ASSERT_DELAY = 16'h0000;
   localparam logic RST_OFF_SOURCE = 1'b0;
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

   // ==========================================================
   // field positions
   // ==========================================================
   localparam int CFG_OFF_SOURCE_BIT = 0;
   localparam int ST_PG_OUT_BIT = 0;
   localparam int ST_SHARE_BIT = 1;
   localparam int ST_WAIT_BIT = 2;
   localparam int PAD_PG_DRIVE_BIT = 15;
   localparam int PAD_ALERT_DRIVE_BIT = 14;
   localparam int PAD_FAULT_DRIVE_LSB = 10;
   localparam int PAD_ADDR_SELECT_PAD1_LSB = 8;
   localparam int PAD_ADDR_SELECT_PAD0_LSB = 6;
   localparam int PAD_CTRL1_BIT = 5;
   localparam int PAD_CTRL0_BIT = 4;
   localparam int PAD_FAULT_LVL_LSB = 0;
   localparam int FAULT_PADS = 4;

   // three-state address pad codes
   localparam logic [1:0] ASEL_HIGH = 2'h3;
   localparam logic [1:0] ASEL_FLOAT = 2'h2;
   localparam logic [1:0] ASEL_LOW = 2'h0;

   // ==========================================================
   // timing
   // ==========================================================
   localparam int CLK_PERIOD_NS = 20;
   localparam int STEP_US = 200;
   localparam int MAX_DELAY_MS = 13100;
   localparam int STEPS_PER_MS = 1000 / STEP_US;
   localparam int MAX_STEPS = MAX_DELAY_MS * STEPS_PER_MS;
   localparam int STEP_CYCLES = (STEP_US * 1000) / CLK_PERIOD_NS;
   localparam int STEP_W = 17;
   localparam int SHARE_EDGES_PER_STEP = 20;
   localparam int SHARE_LOSS_US = 100;
   localparam int SHARE_LOSS_CYCLES = (SHARE_LOSS_US * 1000) / CLK_PERIOD_NS;

   // ==========================================================
   // L11 format
   // ==========================================================
   localparam int L11_MANT_W = 11;
   localparam int L11_EXP_W = 5;

   typedef enum logic [1:0] {
      PG_OFF,
      PG_WAIT,
      PG_ON
   } pg_state_e;

endpackage : pg_delay_pkg

/* rtl/l11_delay_decode.sv */
`timescale 1ns/1ps
module l11_delay_decode (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [pg_delay_pkg::REG_W-1:0] l11_value,
   output logic [pg_delay_pkg::STEP_W-1:0] steps
);
   import pg_delay_pkg::*;

   // ==========================================================
   // L11 milliseconds to clamped, rounded 200us steps
   // ==========================================================
   function automatic logic [STEP_W-1:0] to_steps(
      input logic [REG_W-1:0] v
   );
      logic signed [L11_MANT_W-1:0] mant;
      logic signed [L11_EXP_W-1:0] expo;
      logic signed [63:0] scaled;
      logic [5:0] sh;
      mant = $signed(v[L11_MANT_W-1:0]);
      expo = $signed(v[REG_W-1:L11_MANT_W]);
      scaled = 64'(mant) * 64'(STEPS_PER_MS);
      sh = 6'(-expo);
      if (scaled <= 0) begin
         scaled = 0;
      end else if (expo >= 0) begin
         scaled = scaled <<< expo;
      end else begin
         // round half up before the right shift
         scaled = (scaled + (64'sd1 <<< (sh - 6'd1))) >>> sh;
      end
      if (scaled > 64'(MAX_STEPS)) begin
         scaled = 64'(MAX_STEPS);
      end
      return scaled[STEP_W-1:0];
   endfunction : to_steps

   // RULE_05: L11 decode
   // RULE_03: clamp and round
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         steps <= '0;
      end else begin
         steps <= to_steps(l11_value);
      end
   end

endmodule : l11_delay_decode

/* rtl/pg_time_base.sv */
`timescale 1ns/1ps
module pg_time_base #(
   parameter int STEP_CYC = pg_delay_pkg::STEP_CYCLES,
   parameter int LOSS_CYC = pg_delay_pkg::SHARE_LOSS_CYCLES,
   parameter int SHARE_EDGES = pg_delay_pkg::SHARE_EDGES_PER_STEP
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic share_clk,
   output logic step_tick,
   output logic share_present
);
   import pg_delay_pkg::*;

   logic share_prev;
   logic share_rise;
   logic [31:0] loss_cnt;
   logic [31:0] pre_cnt;
   logic share_prev_present;

   assign share_rise = share_clk & ~share_prev;

   // edge history of the shared clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         share_prev <= 1'b0;
      end else begin
         share_prev <= share_clk;
      end
   end

   // RULE_02: detect shared clock
   // a clock silent for the loss window counts as absent
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loss_cnt <= 32'(LOSS_CYC);
         share_present <= 1'b0;
      end else if (share_rise) begin
         loss_cnt <= '0;
         share_present <= 1'b1;
      end else if (loss_cnt < 32'(LOSS_CYC)) begin
         loss_cnt <= loss_cnt + 32'd1;
      end else begin
         share_present <= 1'b0;
      end
   end

   // RULE_02: select time source
   // prescaler restarts on a source change, so one step may stretch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt <= '0;
         step_tick <= 1'b0;
         share_prev_present <= 1'b0;
      end else begin
         share_prev_present <= share_present;
         step_tick <= 1'b0;
         if (share_present != share_prev_present) begin
            pre_cnt <= '0;
         end else if (share_present) begin
            if (share_rise) begin
               if (pre_cnt >= 32'(SHARE_EDGES - 1)) begin
                  pre_cnt <= '0;
                  step_tick <= 1'b1;
               end else begin
                  pre_cnt <= pre_cnt + 32'd1;
               end
            end
         end else if (pre_cnt >= 32'(STEP_CYC - 1)) begin
            pre_cnt <= '0;
            step_tick <= 1'b1;
         end else begin
            pre_cnt <= pre_cnt + 32'd1;
         end
      end
   end

endmodule : pg_time_base

/* tb/pg_pad_env.sv */
`timescale 1ns/1ps
module pg_pad_env (
   input wire logic share_on,
   input wire logic pg_oe,
   input wire logic al_oe,
   input wire logic [3:0] fault_oe,
   input wire logic [3:0] ext_low,
   output logic share_clk,
   output logic pg_lvl,
   output logic al_lvl,
   output logic [3:0] fault_lvl
);
   // ====================
   // open-drain pads with pull-ups: low while anyone pulls
   assign pg_lvl = ~pg_oe;
   assign al_lvl = ~al_oe;
   assign fault_lvl = ~(fault_oe | ext_low);
   // share clock low when off; offset from pclk edges
   initial begin
      share_clk = 1'b0;
      #3;
      forever #100 share_clk = share_on ? ~share_clk : 1'b0;
   end
endmodule : pg_pad_env

/* tb/powergood_delay_pad_status_props.sv */
`timescale 1ns/1ps
module pg_delay_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pg_delay_pkg::ADDR_W-1:0] paddr,
   input wire logic [pg_delay_pkg::DATA_W-1:0] prdata,
   input wire logic pslverr,
   input wire logic pg_internal_valid,
   input wire logic uv_fast_fault,
   input wire logic pg_off_below_threshold,
   input wire logic alert_pull_req,
   input wire logic [3:0] fault_pull_req,
   input wire logic [3:0] fault_bus_pad_i,
   input wire logic pwrgd_pad_oe,
   input wire logic alert_pad_oe,
   input wire logic [3:0] fault_bus_pad_oe,
   input wire logic addr_select_pad0,
   input wire logic addr_select_pad0_float,
   input wire logic addr_select_pad1,
   input wire logic addr_select_pad1_float,
   input wire logic channel_control_pad0,
   input wire logic channel_control_pad1,
   input wire logic pg_out
);
   import pg_delay_pkg::*;
   // ====================
   // pad word expected from the pins alone; float wins over level
   wire logic [15:0] pad_exp = {~pwrgd_pad_oe, ~alert_pad_oe,
      ~fault_bus_pad_oe[0], ~fault_bus_pad_oe[1],
      ~fault_bus_pad_oe[2], ~fault_bus_pad_oe[3],
      addr_select_pad1 | addr_select_pad1_float,
      addr_select_pad1 & ~addr_select_pad1_float,
      addr_select_pad0 | addr_select_pad0_float,
      addr_select_pad0 & ~addr_select_pad0_float,
      channel_control_pad1, channel_control_pad0,
      fault_bus_pad_i[0], fault_bus_pad_i[1],
      fault_bus_pad_i[2], fault_bus_pad_i[3]};
   wire logic rd_pad = psel && !penable && !pwrite
      && paddr == OFS_PAD_STATUS;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_pad_word_read: assert property (rd_pad |=>
      prdata == {16'h0000, $past(pad_exp)}) else $error("pad word off");
   a_pad_ro_refused: assert property (psel && penable && pwrite
      && paddr == OFS_PAD_STATUS |-> pslverr) else $error("ro write ok");
   a_pg_oe_tracks: assert property (pwrgd_pad_oe == !pg_out)
      else $error("pwrgd pull wrong");
   a_alert_oe_copy: assert property (1'b1 |=>
      alert_pad_oe == $past(alert_pull_req)) else $error("alert pull");
   a_fault_oe_copy: assert property (1'b1 |=>
      fault_bus_pad_oe == $past(fault_pull_req)) else $error("fault pull");
   a_valid_drop_off: assert property (!pg_internal_valid |=>
      !pg_out) else $error("pg stays on without valid");
   a_rise_after_wait: assert property ($rose(pg_out) |->
      $past(pg_internal_valid) && $past(pg_internal_valid, 2))
      else $error("pg rose too early");
   a_on_holds: assert property (pg_out && pg_internal_valid
      && !uv_fast_fault && !pg_off_below_threshold |=> pg_out)
      else $error("pg dropped with no cause");
endmodule : pg_delay_checker

bind powergood_delay_pad_status pg_delay_checker u_chk (.*);

/* tb/powergood_delay_pad_status_tb.sv */
`timescale 1ns/1ps
module powergood_delay_pad_status_tb;
   import pg_delay_pkg::*;
   // ====================
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0, prdata, rd;
   logic [3:0] pstrb = 4'hF, fault_pull_req = 4'h0, ext_low = 4'h0;
   logic [3:0] fb_i, fb_o, fb_oe;
   logic pready, pslverr, share_clk, share_on = 0, er;
   logic valid = 0, uv = 0, thr = 0, alert_req = 0;
   logic pg_i, pg_o, pg_oe, al_i, al_o, al_oe, pg_out;
   logic a0 = 0, a0f = 0, a1 = 0, a1f = 0, c0 = 0, c1 = 0;
   int fail_count = 0, samples_checked = 0, n;
   // pad rows: {a1, a1f, a0, a0f, c1, c0, ext_low} and pad bits 9:0
   logic [9:0] row_in [3] = '{10'h221, 10'h198, 10'h0F0};
   logic [9:0] row_exp [3] = '{10'h327, 10'h2DE, 10'h0BF};

   // short counts keep the run brief
   powergood_delay_pad_status #(.STEP_CYC(10), .LOSS_CYC(20),
      .SHARE_EDGES(2)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .share_clk(share_clk), .pg_internal_valid(valid),
      .uv_fast_fault(uv), .pg_off_below_threshold(thr),
      .alert_pull_req(alert_req), .fault_pull_req(fault_pull_req),
      .pwrgd_pad_i(pg_i), .pwrgd_pad_o(pg_o), .pwrgd_pad_oe(pg_oe),
      .alert_pad_i(al_i), .alert_pad_o(al_o), .alert_pad_oe(al_oe),
      .fault_bus_pad_i(fb_i), .fault_bus_pad_o(fb_o),
      .fault_bus_pad_oe(fb_oe), .addr_select_pad0(a0),
      .addr_select_pad0_float(a0f), .addr_select_pad1(a1),
      .addr_select_pad1_float(a1f), .channel_control_pad0(c0),
      .channel_control_pad1(c1), .pg_out(pg_out));
   pg_pad_env env (.share_on(share_on), .pg_oe(pg_oe), .al_oe(al_oe),
      .fault_oe(fb_oe), .ext_low(ext_low), .share_clk(share_clk),
      .pg_lvl(pg_i), .al_lvl(al_i), .fault_lvl(fb_i));

   always #10 pclk = ~pclk;

   // ====================
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report

   task automatic check(input logic [31:0] seen, exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // one transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d = '0, input logic [3:0] s = 4'hF);
      int i;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i >= 20) begin
         fail_count++;
         final_report();
      end
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb

   // cycles from now until pg_out is seen high
   task automatic wait_pg(output int c);
      for (c = 0; c < 300 && pg_out !== 1'b1; c++) begin
         @(posedge pclk);
      end
      if (c >= 300) begin
         fail_count++;
         final_report();
      end
   endtask : wait_pg

   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      final_report();
   end

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1;
      apb(0, OFS_ASSERT_DELAY);
      check(rd, 32'h0, "delay reset");
      foreach (row_in[i]) begin
         {a1, a1f, a0, a0f, c1, c0, ext_low} <= row_in[i];
         apb(0, OFS_PAD_STATUS);
         check(rd, {16'h0, 6'h1F, row_exp[i]}, "pad row");
      end
      alert_req <= 1;
      fault_pull_req <= 4'b0010;
      apb(0, OFS_PAD_STATUS);
      check(rd, 32'h2CBB, "pad drive");
      check({pg_o, al_o, fb_o}, 0, "pad out");
      alert_req <= 0;
      fault_pull_req <= 4'h0;
      apb(1, OFS_PAD_STATUS, 32'hFFFF);
      check(er, 1, "ro write refused");
      apb(0, 12'h010);
      check({rd[0], er}, 2'b01, "unmapped read");
      apb(1, OFS_ASSERT_DELAY, 32'h7BFF);
      apb(0, OFS_ASSERT_DELAY);
      check(rd, 32'h7BFF, "delay readback");
      apb(1, OFS_ASSERT_DELAY, 32'hAA55, 4'h1);
      apb(0, OFS_ASSERT_DELAY);
      check(rd, 32'h7B55, "lane write");
      // negative delay decodes to none
      apb(1, OFS_ASSERT_DELAY, 32'hFFFF);
      @(posedge pclk);
      valid <= 1;
      wait_pg(n);
      check(n, 3, "zero delay");
      // select 0: the fast comparator is ignored
      uv <= 1;
      repeat (3) @(posedge pclk);
      check(pg_out, 1, "uv ignored");
      uv <= 0;
      thr <= 1;
      repeat (2) @(posedge pclk);
      check(pg_out, 0, "threshold off");
      thr <= 0;
      valid <= 0;
      apb(1, OFS_CONFIG, 32'h1);
      valid <= 1;
      wait_pg(n);
      thr <= 1;
      repeat (3) @(posedge pclk);
      check(pg_out, 1, "threshold ignored");
      thr <= 0;
      uv <= 1;
      repeat (2) @(posedge pclk);
      check(pg_out, 0, "uv off");
      uv <= 0;
      valid <= 0;
      // 1 ms is five steps of ten cycles on the oscillator
      apb(1, OFS_ASSERT_DELAY, 32'h0001);
      valid <= 1;
      wait_pg(n);
      check(n >= 42 && n <= 54, 1, "osc delay");
      valid <= 0;
      // a drop mid-wait restarts the full count
      apb(1, OFS_ASSERT_DELAY, 32'h0001);
      valid <= 1;
      repeat (30) @(posedge pclk);
      valid <= 0;
      @(posedge pclk);
      valid <= 1;
      wait_pg(n);
      check(n >= 42, 1, "restart");
      valid <= 0;
      // 0.75 ms rounds to four steps
      apb(1, OFS_ASSERT_DELAY, 32'hF003);
      valid <= 1;
      wait_pg(n);
      check(n >= 32 && n <= 44, 1, "rounding");
      valid <= 0;
      // share clock steps are twenty cycles; still four steps
      share_on <= 1;
      repeat (40) @(posedge pclk);
      apb(0, OFS_STATE);
      check(rd[1], 1, "share seen");
      valid <= 1;
      wait_pg(n);
      check(n >= 62 && n <= 84, 1, "share delay");
      valid <= 0;
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      apb(0, OFS_ASSERT_DELAY);
      check(rd, 32'h0, "second reset");
      final_report();
   end
endmodule : powergood_delay_pad_status_tb
